// >>> bench/liuhb_bank_test.sv
// Self-checking testbench of the LIU host register bank
`timescale 1ns/100ps
`include "liuhb_map.svh"

module liuhb_bank_test
   import liuhb_pkg::*;
;
   logic          clk_sys_i = 1'b0;
   logic          sys_rst_i = 1'b1;
   liuhb_req_s    reg_req;
   logic [7:0]    reg_rdata;
   liuhb_alarm_s  alarm = '0;
   logic          jitter_off = 1'b0;
   logic          rx_on;
   logic          tx_on;
   logic          tx_oe;
   logic          irq_n;
   int            failures = 0;
   int            total_checks = 0;
   logic [5:0]    zero_ofs [6] = '{6'h00, 6'h01, 6'h20, 6'h21, 6'h30, 6'h31};
   logic [7:0]    ctl_val [4] = '{8'h11, 8'h10, 8'h01, 8'h00};
   logic [3:0]    ctl_pins [4] = '{4'hF, 4'h9, 4'h7, 4'h1};

   always #10 clk_sys_i = ~clk_sys_i;

   liuhb_bank dut_u (
      .clk_sys_i              (clk_sys_i),
      .sys_rst_i              (sys_rst_i),
      .reg_req_i              (reg_req),
      .reg_rdata_o            (reg_rdata),
      .alarm_i                (alarm),
      .jitter_atten_off_i     (jitter_off),
      .receiver_power_on_o    (rx_on),
      .transmitter_power_on_o (tx_on),
      .line_tx_pair_oe_o      (tx_oe),
      .irq_n_o                (irq_n)
   );

   liuhb_host host_u (
      .clk_sys_i   (clk_sys_i),
      .reg_rdata_i (reg_rdata),
      .reg_req_o   (reg_req)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic give_verdict();
      if (failures == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host_u.rd(a, d);
      check(d, exp, "register read");
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask

   task automatic irq_chk(input logic exp);
      check({7'h00, irq_n}, {7'h00, exp}, "interrupt pin");
   endtask

   // Alarm levels pass a two-stage synchroniser, so allow settling time
   task automatic toggle(input int i);
      @(posedge clk_sys_i);
      alarm <= liuhb_alarm_s'(alarm ^ (5'h01 << i));
      settle(6);
   endtask

   task automatic pattern_pulse();
      @(posedge clk_sys_i);
      alarm.pattern_error <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      alarm.pattern_error <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial
   begin
      repeat (20) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      settle(1);
      check({4'h0, rx_on, tx_on, tx_oe, irq_n}, 8'h01, "reset pins");
      foreach (zero_ofs[k])
         rd_chk(zero_ofs[k], 8'h00);
      rd_chk(6'h3E, `LIUHB_PART_ID_DEF);
      host_u.wr(6'h3E, ~`LIUHB_PART_ID_DEF);
      rd_chk(6'h3E, `LIUHB_PART_ID_DEF);
      rd_chk(6'h3F, `LIUHB_REVISION_DEF);
      host_u.wr(6'h3F, ~`LIUHB_REVISION_DEF);
      rd_chk(6'h3F, `LIUHB_REVISION_DEF);
      rd_chk(6'h10, 8'h00);
      foreach (ctl_val[k])
      begin
         host_u.wr(6'h00, ctl_val[k]);
         settle(2);
         check({4'h0, rx_on, tx_on, tx_oe, irq_n}, {4'h0, ctl_pins[k]}, "power pins");
      end
      host_u.wr(6'h00, 8'hFF);
      rd_chk(6'h00, 8'h11);
      host_u.wr(6'h01, 8'h3F);
      host_u.wr(6'h20, 8'h01);
      rd_chk(6'h01, 8'h3F);
      rd_chk(6'h20, 8'h01);
      // Every change counts, so both the rise and the fall of each level
      for (int pass = 0; pass < 2; pass++)
         for (int i = 0; i < 4; i++)
         begin
            toggle(i);
            irq_chk(1'b0);
            rd_chk(6'h21, 8'h01);
            rd_chk(6'h02, 8'(1 << i));
            settle(3);
            irq_chk(1'b1);
            rd_chk(6'h02, 8'h00);
         end
      host_u.wr(6'h20, 8'h00);
      toggle(1);
      irq_chk(1'b1);
      rd_chk(6'h21, 8'h01);
      host_u.wr(6'h20, 8'h01);
      settle(2);
      irq_chk(1'b0);
      host_u.wr(6'h01, 8'h3D);
      settle(2);
      irq_chk(1'b1);
      rd_chk(6'h21, 8'h00);
      rd_chk(6'h02, 8'h02);
      host_u.wr(6'h01, 8'h3F);
      @(posedge clk_sys_i);
      jitter_off <= 1'b1;
      toggle(3);
      irq_chk(1'b1);
      rd_chk(6'h21, 8'h00);
      rd_chk(6'h02, 8'h08);
      rd_chk(6'h03, 8'h0A);
      @(posedge clk_sys_i);
      jitter_off <= 1'b0;
      repeat (3) pattern_pulse();
      settle(4);
      irq_chk(1'b0);
      rd_chk(6'h02, 8'h10);
      rd_chk(6'h30, 8'h00);
      rd_chk(6'h38, 8'h03);
      rd_chk(6'h31, 8'h03);
      give_verdict();
   end

   initial
   begin
      repeat (20000) @(posedge clk_sys_i);
      failures++;
      give_verdict();
   end

endmodule

// >>> bench/liuhb_host.sv
// Host microprocessor model driving the register bank request port
`timescale 1ns/100ps

module liuhb_host
   import liuhb_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic [7:0]  reg_rdata_i,
   output liuhb_req_s       reg_req_o
);
   // Board strap: host register mode, bank in control
   localparam logic control_mode_select = 1'b1;

   initial reg_req_o = '0;

   // ----------------------------------------------------------------
   // Bus cycles
   // ----------------------------------------------------------------
   // Idle fields inverted so a stale address or data cannot pass by luck
   task automatic release_bus();
      @(posedge clk_sys_i);
      reg_req_o.wr    <= 1'b0;
      reg_req_o.rd    <= 1'b0;
      reg_req_o.addr  <= ~reg_req_o.addr;
      reg_req_o.wdata <= ~reg_req_o.wdata;
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      reg_req_o <= {1'b1, 1'b0, a, d};
      release_bus();
   endtask

   // Data sampled one cycle late; read data holds until the next read
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk_sys_i);
      reg_req_o <= {1'b0, 1'b1, a, 8'h00};
      release_bus();
      @(posedge clk_sys_i);
      #1;
      d = reg_rdata_i;
   endtask

endmodule

// >>> hdl/liuhb_bank.sv
// Host control and interrupt register bank of a single-channel line interface unit
// Notes on behaviour
// - Register 0x00 bit 4 turns the receiver on (1) or off (0).
// - Register 0x00 bit 0 enables the transmitter; 0 tristates the line pair.
// - Driver monitor interrupt raised only when its enable bit D0 is set.
// - Receive signal loss interrupt raised only when enable bit D1 is set.
// - Receive lock loss interrupt raised only when enable bit D2 is set.
// - FIFO limit interrupt, enable D3, when FIFO nears overflow or underflow.
// - FIFO limit enable ignored while the jitter attenuator is disabled.
// - Pattern error interrupt raised on bit error when enable D4 set.
// - Counter saturation interrupt when error count reaches 0xFFFF, enable D5.
// - Register 0x20 bit 0 globally gates the interrupt output.
// - Register 0x21 bit 0 reads whether an interrupt is pending.
// - Error count readable as high byte 0x30 and low byte 0x31.
// - Register 0x3E returns a fixed read-only part identity byte.
// - Register 0x3F returns a read-only silicon revision byte.
// - Enabled alarms reach the host through an active-low interrupt pin.
// - The four alarm-level sources latch status on alarm change, pattern error on its rise; cleared when read.
// - Counter saturation flag set at 0xFFFF, cleared on read.
`timescale 1ns/100ps
`include "liuhb_map.svh"

module liuhb_bank
   import liuhb_pkg::*;
#(
   parameter logic [7:0] PART_ID  = `LIUHB_PART_ID_DEF,   // Arbitrary value
   parameter logic [7:0] REVISION = `LIUHB_REVISION_DEF   // Arbitrary value
)
(
   input  wire logic          clk_sys_i,
   input  wire logic          sys_rst_i,
   input  wire liuhb_req_s    reg_req_i,
   output logic      [7:0]    reg_rdata_o,
   input  wire liuhb_alarm_s  alarm_i,
   input  wire logic          jitter_atten_off_i,
   output logic               receiver_power_on_o,
   output logic               transmitter_power_on_o,
   output logic               line_tx_pair_oe_o,
   output logic               irq_n_o
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic hit(input logic       strobe,
                                input logic [5:0] addr,
                                input logic [5:0] ofs);
      hit = strobe && (addr == ofs);
   endfunction

   // ----------------------------------------------------------------
   // Alarm pin synchronisers and change detection
   // ----------------------------------------------------------------
   liuhb_alarm_s alarm_meta_r;
   liuhb_alarm_s alarm_sync_r;
   liuhb_alarm_s alarm_prev_r;

   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         alarm_meta_r <= '0;
         alarm_sync_r <= '0;
         alarm_prev_r <= '0;
      end
      else
      begin
         alarm_meta_r <= alarm_i;
         alarm_sync_r <= alarm_meta_r;
         alarm_prev_r <= alarm_sync_r;
      end
   end

   liuhb_alarm_s alarm_change;
   logic         pattern_err_evt;

   assign alarm_change    = alarm_sync_r ^ alarm_prev_r;
   // Error pulse seen if it spans one clock edge; counted once per rise
   assign pattern_err_evt = alarm_sync_r.pattern_error & ~alarm_prev_r.pattern_error;

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   logic       rx_on_r;
   logic       tx_on_r;
   logic [5:0] src_en_r;
   logic       global_irq_enable_r;

   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         rx_on_r <= 1'b0;
         tx_on_r <= 1'b0;
      end
      else if (hit(reg_req_i.wr, reg_req_i.addr, `LIUHB_OFS_REDUNDANCY))
      begin
         rx_on_r <= reg_req_i.wdata[`LIUHB_BIT_RX_ON];
         tx_on_r <= reg_req_i.wdata[`LIUHB_BIT_TX_ON];
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         src_en_r <= `LIUHB_RST_SRC;
      end
      else if (hit(reg_req_i.wr, reg_req_i.addr, `LIUHB_OFS_SRC_IRQ_EN))
      begin
         src_en_r <= reg_req_i.wdata[`LIUHB_SRC_N-1:0];
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         global_irq_enable_r <= 1'b0;
      end
      else if (hit(reg_req_i.wr, reg_req_i.addr, `LIUHB_OFS_GLOBAL_EN))
      begin
         global_irq_enable_r <= reg_req_i.wdata[`LIUHB_BIT_GLOBAL];
      end
   end

   assign receiver_power_on_o    = rx_on_r;
   assign transmitter_power_on_o = tx_on_r;
   assign line_tx_pair_oe_o      = tx_on_r;

   // ----------------------------------------------------------------
   // Pattern error counter and holding register
   // ----------------------------------------------------------------
   logic [15:0] err_count_r;
   logic [7:0]  holding_r;
   logic        count_sat_evt;

   // Stops at the top so software never sees a wrap to a small count
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         err_count_r <= `LIUHB_RST_COUNT;
      end
      else if (pattern_err_evt && (err_count_r != `LIUHB_COUNT_MAX))
      begin
         err_count_r <= err_count_r + 16'h0001;
      end
   end

   assign count_sat_evt = pattern_err_evt && (err_count_r == `LIUHB_COUNT_MAX - 16'h0001);

   // Low byte frozen at the high-byte read, so the pair reads coherently
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         holding_r <= `LIUHB_RST_BYTE;
      end
      else if (hit(reg_req_i.rd, reg_req_i.addr, `LIUHB_OFS_COUNT_HIGH))
      begin
         holding_r <= err_count_r[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Latched status and interrupt
   // ----------------------------------------------------------------
   logic [5:0] src_set;
   logic [5:0] src_status;
   logic [5:0] src_en_eff;
   logic       irq_pending;
   logic       irq_n_r;

   always_comb
   begin
      src_set                          = '0;
      src_set[`LIUHB_SRC_DMO]          = alarm_change.driver_monitor_alarm;
      src_set[`LIUHB_SRC_SIG_LOSS]     = alarm_change.rx_signal_loss;
      src_set[`LIUHB_SRC_LOCK_LOSS]    = alarm_change.rx_lock_loss;
      src_set[`LIUHB_SRC_FIFO_LIMIT]   = alarm_change.fifo_limit_alarm;
      src_set[`LIUHB_SRC_PATTERN_ERR]  = pattern_err_evt;
      src_set[`LIUHB_SRC_CNT_SAT]      = count_sat_evt;
   end

   liuhb_sticky u_sticky
   (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .set_i     (src_set),
      .clr_i     (hit(reg_req_i.rd, reg_req_i.addr, `LIUHB_OFS_SRC_IRQ_STAT)),
      .status_o  (src_status)
   );

   // FIFO limit enable dropped while the attenuator is off
   always_comb
   begin
      src_en_eff                        = src_en_r;
      src_en_eff[`LIUHB_SRC_FIFO_LIMIT] = src_en_r[`LIUHB_SRC_FIFO_LIMIT]
                                          & ~jitter_atten_off_i;
   end

   assign irq_pending = |(src_status & src_en_eff);

   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         irq_n_r <= 1'b1;
      end
      else
      begin
         irq_n_r <= ~(global_irq_enable_r & irq_pending);
      end
   end

   assign irq_n_o = irq_n_r;

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   always_comb
   begin
      rdata_nxt = `LIUHB_RST_BYTE;
      case (reg_req_i.addr)
         `LIUHB_OFS_REDUNDANCY:
         begin
            rdata_nxt[`LIUHB_BIT_RX_ON] = rx_on_r;
            rdata_nxt[`LIUHB_BIT_TX_ON] = tx_on_r;
         end
         `LIUHB_OFS_SRC_IRQ_EN:   rdata_nxt[5:0] = src_en_r;
         `LIUHB_OFS_SRC_IRQ_STAT: rdata_nxt[5:0] = src_status;
         `LIUHB_OFS_ALARM_STAT:
         begin
            rdata_nxt[3:0] = {alarm_sync_r.fifo_limit_alarm, alarm_sync_r.rx_lock_loss,
                              alarm_sync_r.rx_signal_loss, alarm_sync_r.driver_monitor_alarm};
         end
         `LIUHB_OFS_GLOBAL_EN:    rdata_nxt[0] = global_irq_enable_r;
         `LIUHB_OFS_GLOBAL_STAT:  rdata_nxt[0] = irq_pending;
         `LIUHB_OFS_COUNT_HIGH:   rdata_nxt = err_count_r[15:8];
         `LIUHB_OFS_COUNT_LOW:    rdata_nxt = err_count_r[7:0];
         `LIUHB_OFS_HOLDING:      rdata_nxt = holding_r;
         `LIUHB_OFS_PART_ID:      rdata_nxt = PART_ID;
         `LIUHB_OFS_REVISION:     rdata_nxt = REVISION;
         default:                 rdata_nxt = `LIUHB_RST_BYTE;
      endcase
   end

   // Data held between reads so a slow serial shifter can pick it up
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         rdata_r <= `LIUHB_RST_BYTE;
      end
      else if (reg_req_i.rd)
      begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata_o = rdata_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   chk_rx_power_bit: assert property (
      hit(reg_req_i.wr, reg_req_i.addr, `LIUHB_OFS_REDUNDANCY)
      |=> receiver_power_on_o == $past(reg_req_i.wdata[`LIUHB_BIT_RX_ON]))
      else $error("Receiver power does not follow register write");

   chk_tx_tristate: assert property (
      hit(reg_req_i.wr, reg_req_i.addr, `LIUHB_OFS_REDUNDANCY)
      |=> line_tx_pair_oe_o == $past(reg_req_i.wdata[`LIUHB_BIT_TX_ON]))
      else $error("Line pair drive does not follow transmitter bit");

   chk_dmo_irq: assert property (
      global_irq_enable_r && src_en_r[0] && src_status[0] |=> !irq_n_o)
      else $error("Enabled driver monitor status gave no interrupt");

   chk_los_irq: assert property (
      global_irq_enable_r && src_en_r[1] && src_status[1] |=> !irq_n_o)
      else $error("Enabled signal loss status gave no interrupt");

   chk_lol_irq: assert property (
      global_irq_enable_r && src_en_r[2] && src_status[2] |=> !irq_n_o)
      else $error("Enabled lock loss status gave no interrupt");

   chk_fifo_irq: assert property (
      global_irq_enable_r && src_en_r[3] && src_status[3] && !jitter_atten_off_i
      |=> !irq_n_o)
      else $error("Enabled fifo limit status gave no interrupt");

   chk_fifo_ignored: assert property (
      jitter_atten_off_i && ((src_status & src_en_r & 6'h37) == 6'h00) |=> irq_n_o)
      else $error("Fifo limit interrupt with attenuator disabled");

   chk_prbs_irq: assert property (
      global_irq_enable_r && src_en_r[4] && pattern_err_evt ##1 global_irq_enable_r
      && src_en_r[4] |=> !irq_n_o)
      else $error("Pattern error gave no interrupt");

   chk_sat_flag: assert property (
      $rose(err_count_r == `LIUHB_COUNT_MAX) |-> src_status[`LIUHB_SRC_CNT_SAT])
      else $error("Saturation flag not set when count reached top");

   chk_global_gate: assert property (
      !global_irq_enable_r |=> irq_n_o)
      else $error("Interrupt asserted with global enable clear");

   chk_pending_read: assert property (
      hit(reg_req_i.rd, reg_req_i.addr, `LIUHB_OFS_GLOBAL_STAT)
      |=> reg_rdata_o == {7'h00, $past(irq_pending)})
      else $error("Pending flag read mismatch");

   chk_count_read: assert property (
      hit(reg_req_i.rd, reg_req_i.addr, `LIUHB_OFS_COUNT_LOW)
      |=> reg_rdata_o == $past(err_count_r[7:0]))
      else $error("Low count byte read mismatch");

   chk_id_read: assert property (
      hit(reg_req_i.rd, reg_req_i.addr, `LIUHB_OFS_PART_ID) |=> reg_rdata_o == PART_ID)
      else $error("Identity read mismatch");

   chk_rev_read: assert property (
      hit(reg_req_i.rd, reg_req_i.addr, `LIUHB_OFS_REVISION) |=> reg_rdata_o == REVISION)
      else $error("Revision read mismatch");

   chk_clear_read: assert property (
      hit(reg_req_i.rd, reg_req_i.addr, `LIUHB_OFS_SRC_IRQ_STAT) && (src_set == 6'h00)
      |=> src_status == 6'h00)
      else $error("Status not cleared by read");

   chk_irq_cause: assert property (
      !irq_n_o |-> $past(global_irq_enable_r && irq_pending))
      else $error("Interrupt without enabled latched source");

   cov_irq_raise: cover property (global_irq_enable_r ##1 $fell(irq_n_o));
   cov_count_sat: cover property ($rose(err_count_r == `LIUHB_COUNT_MAX));
   cov_set_on_clear: cover property (
      hit(reg_req_i.rd, reg_req_i.addr, `LIUHB_OFS_SRC_IRQ_STAT) && (src_set != 6'h00));
   cov_tx_off: cover property ($fell(line_tx_pair_oe_o));

endmodule

// >>> hdl/liuhb_sticky.sv
// Clear-on-read latched interrupt status bits
`timescale 1ns/100ps
`include "liuhb_map.svh"

module liuhb_sticky
   import liuhb_pkg::*;
(
   input  wire logic                      clk_sys_i,
   input  wire logic                      sys_rst_i,
   input  wire logic [`LIUHB_SRC_N-1:0]   set_i,
   input  wire logic                      clr_i,
   output logic      [`LIUHB_SRC_N-1:0]   status_o
);

   logic [`LIUHB_SRC_N-1:0] status_r;
   logic [`LIUHB_SRC_N-1:0] status_nxt;

   // Set beats clear so an event in the read cycle survives
   always_comb
   begin
      status_nxt = (status_r & ~{`LIUHB_SRC_N{clr_i}}) | set_i;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         status_r <= `LIUHB_RST_SRC;
      end
      else
      begin
         status_r <= status_nxt;
      end
   end

   assign status_o = status_r;

endmodule

// >>> include/liuhb_map.svh
// Register offsets, field positions, reset values and identity defaults of the LIU register bank
`ifndef LIUHB_MAP_SVH
`define LIUHB_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LIUHB_ADDR_W            6
`define LIUHB_OFS_REDUNDANCY    6'h00
`define LIUHB_OFS_SRC_IRQ_EN    6'h01
`define LIUHB_OFS_SRC_IRQ_STAT  6'h02
`define LIUHB_OFS_ALARM_STAT    6'h03
`define LIUHB_OFS_GLOBAL_EN     6'h20
`define LIUHB_OFS_GLOBAL_STAT   6'h21
`define LIUHB_OFS_COUNT_HIGH    6'h30
`define LIUHB_OFS_COUNT_LOW     6'h31
`define LIUHB_OFS_HOLDING       6'h38
`define LIUHB_OFS_PART_ID       6'h3E
`define LIUHB_OFS_REVISION      6'h3F

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LIUHB_BIT_TX_ON         0
`define LIUHB_BIT_RX_ON         4
`define LIUHB_BIT_GLOBAL        0
`define LIUHB_SRC_DMO           0
`define LIUHB_SRC_SIG_LOSS      1
`define LIUHB_SRC_LOCK_LOSS     2
`define LIUHB_SRC_FIFO_LIMIT    3
`define LIUHB_SRC_PATTERN_ERR   4
`define LIUHB_SRC_CNT_SAT       5
`define LIUHB_SRC_N             6

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define LIUHB_RST_BYTE          8'h00
`define LIUHB_RST_SRC           6'h00
`define LIUHB_RST_COUNT         16'h0000
`define LIUHB_COUNT_MAX         16'hFFFF
`define LIUHB_PART_ID_DEF       8'h5A
`define LIUHB_REVISION_DEF      8'h01

`endif

// >>> include/liuhb_pkg.sv
// Types shared by the LIU register bank modules
package liuhb_pkg;

   // Host register access, one request per clock
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [5:0] addr;
      logic [7:0] wdata;
   } liuhb_req_s;

   // Alarm levels and the pattern error event from the line side
   typedef struct packed {
      logic pattern_error;
      logic fifo_limit_alarm;
      logic rx_lock_loss;
      logic rx_signal_loss;
      logic driver_monitor_alarm;
   } liuhb_alarm_s;

endpackage
